// *** src/mic_pkg.sv ***
// Package of constants and carrier types for the interrupt controller
package mic_pkg;

    // Source count and bit positions in flag/enable words
    localparam int          NUM_SRC      = 7;
    localparam int          SRC_EXT_ONE  = 0;
    localparam int          SRC_EXT_TWO  = 1;
    localparam int          SRC_CONV     = 2;
    localparam int          SRC_T16      = 3;
    localparam int          SRC_CMP      = 4;
    localparam int          SRC_T8A      = 5;
    localparam int          SRC_T8B      = 6;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0]  OFS_ENABLE   = 8'h00;
    localparam logic [7:0]  OFS_REQUEST  = 8'h04;
    localparam logic [7:0]  OFS_EDGE     = 8'h08;
    localparam logic [7:0]  OFS_SP       = 8'h0C;
    localparam logic [7:0]  OFS_CTRL     = 8'h10;
    localparam logic [7:0]  OFS_EVT      = 8'h14;
    localparam logic [7:0]  OFS_EVT_MASK = 8'h18;

    // Bit positions in the control/status register
    localparam int          CTRL_GIE     = 0;
    localparam int          CTRL_ACTIVE  = 1;

    // Event status bits: interrupt taken, return done
    localparam int          EVT_ENTRY    = 0;
    localparam int          EVT_RETURN   = 1;
    localparam int          NUM_EVT      = 2;

    // Values after reset, plus vector address and pointer step
    localparam logic [6:0]  RST_ENABLE   = 7'h00;
    localparam logic [6:0]  RST_REQUEST  = 7'h00;
    localparam logic [13:0] RST_EDGE     = 14'h1555;
    localparam logic [7:0]  RST_SP       = 8'h00;
    localparam logic [15:0] VECTOR_ADDR  = 16'h0010;
    localparam logic [7:0]  SP_STEP      = 8'h02;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Edge select codes per source
    typedef enum logic [1:0] {
        EDGE_BOTH    = 2'h0,
        EDGE_RISE    = 2'h1,
        EDGE_FALL    = 2'h2,
        EDGE_RSVD    = 2'h3
    } mic_edge_t;

    // CPU instruction strobes toward the controller
    typedef struct packed {
        logic        set_gie;
        logic        clr_gie;
        logic        ret;
        logic        push_af;
        logic        pop_af;
        logic [15:0] pc;
        logic [7:0]  acc;
        logic [7:0]  flags;
    } mic_cpu_req_t;

    // Stack memory access toward data memory
    typedef struct packed {
        logic        we;
        logic        re;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } mic_mem_req_t;

    // Controller answer to the CPU sequencer
    typedef struct packed {
        logic        load_pc;
        logic [15:0] pc;
        logic        load_af;
        logic [7:0]  acc;
        logic [7:0]  flags;
        logic        busy;
    } mic_cpu_rsp_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_RET_RD,
        ST_RET_LD,
        ST_POP_RD,
        ST_POP_LD
    } mic_state_t;

endpackage

// *** src/mic_irq_ctrl.sv ***
// Interrupt controller: request flags, masking, entry/return sequencer, AXI4-Lite regs
// Function
// - Seven request sources: two external pin pairs, converter, three timers, comparator.
// - Each source has its own enable bit gating dispatch.
// - Flags set only by hardware; software clears them via the flag register.
// - Edge select picks rising, falling or both edges per source.
// - Global enable gates all requests; enable and disable instructions set/clear it.
// - On entry push PC at pointer, pointer plus two, clear global enable, vector.
// - On return pop PC, pointer minus two, set global enable, resume.
// - Flags still set by events while the source enable is zero.
// - Service routine can read the request flag register.
// - Push and pop instructions save and restore working and flag registers.
// - Build option picks one of two pins for each external source.
`timescale 1ns/1ps
module mic_irq_ctrl
    import mic_pkg::*;
#(
    parameter bit EXT_ONE_ALT = 1'b0,
    parameter bit EXT_TWO_ALT = 1'b0
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,

    input  wire logic [1:0]          ext_pin_pair_one,
    input  wire logic [1:0]          ext_pin_pair_two,
    input  wire logic                conv_level,
    input  wire logic                sixteen_bit_timer_level,
    input  wire logic                comparator_unit_level,
    input  wire logic                eight_bit_timer_a_level,
    input  wire logic                eight_bit_timer_b_level,

    input  wire logic                insn_boundary,
    input  wire mic_pkg::mic_cpu_req_t cpu_req,
    output      mic_pkg::mic_cpu_rsp_t cpu_rsp,
    output      mic_pkg::mic_mem_req_t mem_req,
    input  wire logic [15:0]         mem_rdata,

    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    output      logic [1:0]          s_axi_bresp,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    output      logic [31:0]         s_axi_rdata,
    output      logic [1:0]          s_axi_rresp,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,

    output      logic                irq
);
    import mic_pkg::*;

    // Elaboration check: source layout is fixed at seven lines
    if (NUM_SRC != 7)
    begin : g_bad_src
        $error("mic_irq_ctrl supports exactly seven sources");
    end

    // All state of the block
    typedef struct packed {
        logic [NUM_SRC-1:0]   sync1;
        logic [NUM_SRC-1:0]   sync2;
        logic [NUM_SRC-1:0]   prev;
        logic [NUM_SRC-1:0]   request;
        logic [NUM_SRC-1:0]   enable;
        logic [2*NUM_SRC-1:0] edge_sel;
        logic [7:0]           sp;
        logic                 gie;
        logic [NUM_EVT-1:0]   evt;
        logic [NUM_EVT-1:0]   evt_mask;

        mic_state_t           state;
        mic_cpu_rsp_t         rsp;
        mic_mem_req_t         mem;

        logic                 aw_held;
        logic [7:0]           aw_addr;
        logic                 w_held;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;

        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } mic_regs_t;

    mic_regs_t           r_ff;
    mic_regs_t           nxt_r;

    logic [NUM_SRC-1:0]  raw_src;
    logic [NUM_SRC-1:0]  hw_set;
    logic                take_irq;
    logic                wr_go;
    logic                rd_go;

    // Edge detect by select code; reserved code treated as both edges
    function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                      input logic old);
        case (sel)
            EDGE_RISE: edge_hit = cur & ~old;
            EDGE_FALL: edge_hit = ~cur & old;
            default:   edge_hit = cur ^ old;
        endcase
    endfunction

    // Address decode shared by read and write paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == OFS_ENABLE) || (a == OFS_REQUEST) || (a == OFS_EDGE) ||
                  (a == OFS_SP) || (a == OFS_CTRL) || (a == OFS_EVT) ||
                  (a == OFS_EVT_MASK);
    endfunction

    // Pin pair selection fixed at build time
    assign raw_src[SRC_EXT_ONE] = ext_pin_pair_one[EXT_ONE_ALT];
    assign raw_src[SRC_EXT_TWO] = ext_pin_pair_two[EXT_TWO_ALT];
    assign raw_src[SRC_CONV]    = conv_level;
    assign raw_src[SRC_T16]     = sixteen_bit_timer_level;
    assign raw_src[SRC_CMP]     = comparator_unit_level;
    assign raw_src[SRC_T8A]     = eight_bit_timer_a_level;
    assign raw_src[SRC_T8B]     = eight_bit_timer_b_level;

    // Per-source edge detect on the second synchroniser stage
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_edge
            assign hw_set[gi] = edge_hit(r_ff.edge_sel[2*gi +: 2], r_ff.sync2[gi],
                                         r_ff.prev[gi]);
        end
    endgenerate

    // Dispatch needs global enable, an enabled pending flag and an idle sequencer
    assign take_irq = r_ff.gie && |(r_ff.request & r_ff.enable) &&
                      insn_boundary && (r_ff.state == ST_IDLE);

    // AXI handshakes are combinational from the hold flags
    assign s_axi_awready = ~r_ff.aw_held;
    assign s_axi_wready  = ~r_ff.w_held;
    assign s_axi_arready = ~r_ff.rvalid;
    assign s_axi_bvalid  = r_ff.bvalid;
    assign s_axi_bresp   = r_ff.bresp;
    assign s_axi_rvalid  = r_ff.rvalid;
    assign s_axi_rdata   = r_ff.rdata;
    assign s_axi_rresp   = r_ff.rresp;
    assign cpu_rsp       = r_ff.rsp;
    assign mem_req       = r_ff.mem;
    assign irq           = |(r_ff.evt & r_ff.evt_mask);
    assign wr_go         = r_ff.aw_held && r_ff.w_held && !r_ff.bvalid;
    assign rd_go         = s_axi_arvalid && !r_ff.rvalid;

    // Next-state logic for the whole block
    always_comb
    begin
        nxt_r = r_ff;
        // Two-flop synchroniser, then edge history
        nxt_r.sync1 = raw_src;
        nxt_r.sync2 = r_ff.sync1;
        nxt_r.prev  = r_ff.sync2;
        nxt_r.rsp.load_pc = 1'b0;
        nxt_r.rsp.load_af = 1'b0;
        nxt_r.mem.we = 1'b0;
        nxt_r.mem.re = 1'b0;

        // Capture address and data in either order
        if (s_axi_awvalid && !r_ff.aw_held)
        begin
            nxt_r.aw_held = 1'b1;
            nxt_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_ff.w_held)
        begin
            nxt_r.w_held = 1'b1;
            nxt_r.w_data = s_axi_wdata;
            nxt_r.w_strb = s_axi_wstrb;
        end

        // Register write; only byte lane 0 or 1 carries data
        if (wr_go)
        begin
            nxt_r.aw_held = 1'b0;
            nxt_r.w_held  = 1'b0;
            nxt_r.bvalid  = 1'b1;
            nxt_r.bresp   = addr_ok(r_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (r_ff.w_strb[0])
            begin
                case (r_ff.aw_addr)
                    OFS_ENABLE:   nxt_r.enable = r_ff.w_data[NUM_SRC-1:0];
                    OFS_REQUEST:  nxt_r.request = r_ff.request &
                                                  r_ff.w_data[NUM_SRC-1:0];
                    OFS_EDGE:     nxt_r.edge_sel[7:0] = r_ff.w_data[7:0];
                    OFS_SP:       nxt_r.sp = r_ff.w_data[7:0];
                    OFS_EVT_MASK: nxt_r.evt_mask = r_ff.w_data[NUM_EVT-1:0];
                    // Read-only or unmapped: left alone
                    default:      ;
                endcase
            end
            if (r_ff.w_strb[1] && r_ff.aw_addr == OFS_EDGE)
                nxt_r.edge_sel[13:8] = r_ff.w_data[13:8];
        end
        if (r_ff.bvalid && s_axi_bready)
            nxt_r.bvalid = 1'b0;

        // Register read; reading event status clears it
        if (rd_go)
        begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_ENABLE:   nxt_r.rdata = {25'h0, r_ff.enable};
                OFS_REQUEST:  nxt_r.rdata = {25'h0, r_ff.request};
                OFS_EDGE:     nxt_r.rdata = {18'h0, r_ff.edge_sel};
                OFS_SP:       nxt_r.rdata = {24'h0, r_ff.sp};
                OFS_CTRL:     nxt_r.rdata = {30'h0, (r_ff.state != ST_IDLE), r_ff.gie};
                OFS_EVT:
                begin
                    nxt_r.rdata = {30'h0, r_ff.evt};
                    nxt_r.evt   = '0;
                end
                OFS_EVT_MASK: nxt_r.rdata = {30'h0, r_ff.evt_mask};
                default:      nxt_r.rdata = 32'h0;
            endcase
        end
        if (r_ff.rvalid && s_axi_rready)
            nxt_r.rvalid = 1'b0;

        // Hardware sets apply after the clear, so a set wins
        nxt_r.request = nxt_r.request | hw_set;

        // Instruction-driven global enable
        if (cpu_req.set_gie)
            nxt_r.gie = 1'b1;
        if (cpu_req.clr_gie)
            nxt_r.gie = 1'b0;

        // Entry and return sequencer
        case (r_ff.state)
            ST_IDLE:
            begin
                nxt_r.rsp.busy = 1'b0;
                if (take_irq)
                begin
                    // Pointer LSB is assumed zero; two-byte slot
                    nxt_r.mem.we    = 1'b1;
                    nxt_r.mem.addr  = r_ff.sp;
                    nxt_r.mem.wdata = cpu_req.pc;
                    nxt_r.sp        = r_ff.sp + SP_STEP;
                    nxt_r.gie       = 1'b0;
                    nxt_r.rsp.busy  = 1'b1;
                    nxt_r.state     = ST_ENTRY;
                end
                else if (cpu_req.ret)
                begin
                    nxt_r.sp       = r_ff.sp - SP_STEP;
                    nxt_r.mem.re   = 1'b1;
                    nxt_r.mem.addr = r_ff.sp - SP_STEP;
                    nxt_r.rsp.busy = 1'b1;
                    nxt_r.state    = ST_RET_RD;
                end
                else if (cpu_req.push_af)
                begin
                    nxt_r.mem.we    = 1'b1;
                    nxt_r.mem.addr  = r_ff.sp;
                    nxt_r.mem.wdata = {cpu_req.flags, cpu_req.acc};
                    nxt_r.sp        = r_ff.sp + SP_STEP;
                end
                else if (cpu_req.pop_af)
                begin
                    nxt_r.sp       = r_ff.sp - SP_STEP;
                    nxt_r.mem.re   = 1'b1;
                    nxt_r.mem.addr = r_ff.sp - SP_STEP;
                    nxt_r.rsp.busy = 1'b1;
                    nxt_r.state    = ST_POP_RD;
                end
            end
            ST_ENTRY:
            begin
                // Redirect fetch to the vector
                nxt_r.rsp.load_pc = 1'b1;
                nxt_r.rsp.pc      = VECTOR_ADDR;
                nxt_r.rsp.busy    = 1'b0;
                nxt_r.evt[EVT_ENTRY] = 1'b1;
                nxt_r.state       = ST_IDLE;
            end
            ST_RET_RD:
                nxt_r.state = ST_RET_LD;
            ST_RET_LD:
            begin
                // Memory data valid one cycle after the read strobe
                nxt_r.rsp.load_pc = 1'b1;
                nxt_r.rsp.pc      = mem_rdata;
                nxt_r.gie         = 1'b1;
                nxt_r.rsp.busy    = 1'b0;
                nxt_r.evt[EVT_RETURN] = 1'b1;
                nxt_r.state       = ST_IDLE;
            end
            ST_POP_RD:
                nxt_r.state = ST_POP_LD;
            ST_POP_LD:
            begin
                nxt_r.rsp.load_af = 1'b1;
                nxt_r.rsp.acc     = mem_rdata[7:0];
                nxt_r.rsp.flags   = mem_rdata[15:8];
                nxt_r.rsp.busy    = 1'b0;
                nxt_r.state       = ST_IDLE;
            end
            default:
                nxt_r.state = ST_IDLE;
        endcase
    end

    // Single register stage with synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_ff          <= '0;
            r_ff.request  <= RST_REQUEST;
            r_ff.enable   <= RST_ENABLE;
            r_ff.edge_sel <= RST_EDGE;
            r_ff.sp       <= RST_SP;
            r_ff.state    <= ST_IDLE;
            r_ff.bresp    <= RESP_OKAY;
            r_ff.rresp    <= RESP_OKAY;
        end
        else
            r_ff <= nxt_r;
    end

endmodule // mic_irq_ctrl

// *** tb/mic_mem_model.sv ***
// Stack memory model standing behind the controller's memory port
`timescale 1ns/1ps
module mic_mem_model
    import mic_pkg::*;
(
    input  wire logic                  aclk,
    input  wire mic_pkg::mic_mem_req_t mem_req,
    output      logic [15:0]           mem_rdata = 16'h0000
);
    logic [7:0] mem [256];

    // Each saved word fills a two-byte slot, low byte first
    always @(posedge aclk)
    begin
        if (mem_req.we)
        begin
            mem[mem_req.addr]         <= mem_req.wdata[7:0];
            mem[mem_req.addr + 8'h01] <= mem_req.wdata[15:8];
        end
        // Data stands one cycle; the inverse after it exposes a late sample
        if (mem_req.re)
            mem_rdata <= {mem[mem_req.addr + 8'h01], mem[mem_req.addr]};
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule // mic_mem_model

// *** tb/mic_irq_ctrl_assertions.sv ***
// Port checker for the interrupt controller
`timescale 1ns/1ps
module mic_irq_ctrl_assertions
    import mic_pkg::*;
(
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire mic_pkg::mic_cpu_req_t cpu_req,
    input wire mic_pkg::mic_cpu_rsp_t cpu_rsp,
    input wire mic_pkg::mic_mem_req_t mem_req,
    input wire logic [15:0]           mem_rdata,
    input wire logic [7:0]            s_axi_awaddr,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [7:0]            s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Sequencer steps
    sequence s_ret_go;
        cpu_req.ret && !cpu_rsp.busy;
    endsequence
    sequence s_pop_go;
        cpu_req.pop_af && !cpu_rsp.busy;
    endsequence
    sequence s_vector;
        cpu_rsp.load_pc && (cpu_rsp.pc == VECTOR_ADDR);
    endsequence

    // A push not caused by the push instruction is an entry
    property p_entry;
        mem_req.we && !$past(cpu_req.push_af) |->
            (mem_req.wdata == $past(cpu_req.pc)) ##1 s_vector;
    endproperty
    a_entry: assert property (p_entry) else $error("entry push or vector wrong");
    property p_ret;
        s_ret_go |=> (mem_req.re && cpu_rsp.busy) ##2
            (cpu_rsp.load_pc && (cpu_rsp.pc == $past(mem_rdata)));
    endproperty
    a_ret: assert property (p_ret) else $error("return restore wrong");
    property p_pop;
        s_pop_go |=> mem_req.re ##2
            (cpu_rsp.load_af && ({cpu_rsp.flags, cpu_rsp.acc} == $past(mem_rdata)));
    endproperty
    a_pop: assert property (p_pop) else $error("pop restore wrong");
    property p_push;
        cpu_req.push_af && !cpu_rsp.busy |=>
            mem_req.we && (mem_req.wdata == {$past(cpu_req.flags), $past(cpu_req.acc)});
    endproperty
    a_push: assert property (p_push) else $error("push data wrong");

    // Register bus answers
    property p_rd_err;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr > OFS_EVT_MASK) |=>
            s_axi_rvalid && (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == 32'h0);
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read answer wrong");
    property p_rd_ok;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr <= OFS_EVT_MASK)
            && (s_axi_araddr[1:0] == 2'h0) |=> s_axi_rvalid && (s_axi_rresp == RESP_OKAY);
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("mapped read answer wrong");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer not held");
    property p_wr_err;
        s_axi_awvalid && s_axi_awready && (s_axi_awaddr > OFS_EVT_MASK) |->
            ##[1:8] (s_axi_bvalid && (s_axi_bresp == RESP_SLVERR));
    endproperty
    a_wr_err: assert property (p_wr_err) else $error("unmapped write answer wrong");
endmodule // mic_irq_ctrl_assertions

bind mic_irq_ctrl mic_irq_ctrl_assertions u_mic_irq_ctrl_assertions (
    .aclk(aclk), .aresetn(aresetn), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// *** tb/mic_irq_ctrl_tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module mic_irq_ctrl_tb;
    import mic_pkg::*;
    int            n_checks = 0;
    int            fail_count = 0;
    int            cyc = 0;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [6:0]    src = 7'h00;
    logic          insn_boundary = 1'b1;
    mic_cpu_req_t  cpu_req = '0;
    mic_cpu_rsp_t  cpu_rsp;
    mic_mem_req_t  mem_req;
    logic [15:0]   mem_rdata;
    logic [7:0]    aw = 8'h00;
    logic [7:0]    ar = 8'h00;
    logic [31:0]   wd = 32'h0;
    logic          awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
    logic          awr, wrdy, bv, arr, rv, irq;
    logic [1:0]    br, rr;
    logic [31:0]   rdat;
    logic [31:0]   seed = 32'h7;
    logic [33:0]   rd_q[$];
    logic [1:0]    b_q[$];
    logic [15:0]   pc_q[$];
    logic [15:0]   af_q[$];

    mic_irq_ctrl u_mic_irq_ctrl (
        .aclk(aclk), .aresetn(aresetn), .ext_pin_pair_one({~src[0], src[0]}),
        .ext_pin_pair_two({~src[1], src[1]}), .conv_level(src[2]),
        .sixteen_bit_timer_level(src[3]), .comparator_unit_level(src[4]),
        .eight_bit_timer_a_level(src[5]), .eight_bit_timer_b_level(src[6]),
        .insn_boundary(insn_boundary), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .irq(irq)
    );
    mic_mem_model u_mic_mem_model (.aclk(aclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    initial forever #25 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Address and data offered together; ready raised late at random
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] e = RESP_OKAY);
        logic da = 1'b0;
        logic dw = 1'b0;
        b_q.push_back(e);
        @(posedge aclk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(da && dw))
        begin
            @(posedge aclk);
            da = da | awr;
            dw = dw | wrdy;
            if (da) awv <= 1'b0;
            if (dw) wv <= 1'b0;
        end
        if (rnd() & 1) @(posedge aclk);
        brd <= 1'b1;
        do @(posedge aclk); while (!bv);
        brd <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] e = RESP_OKAY);
        rd_q.push_back({e, d});
        @(posedge aclk);
        ar <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        if (rnd() & 1) @(posedge aclk);
        rrd <= 1'b1;
        do @(posedge aclk); while (!rv);
        rrd <= 1'b0;
    endtask

    // One-cycle instruction strobe: bits are set, clr, ret, push, pop
    task automatic ins(input logic [4:0] op);
        @(posedge aclk);
        cpu_req[36:32] <= op;
        @(posedge aclk);
        cpu_req[36:32] <= 5'h00;
        repeat (4) @(posedge aclk);
    endtask

    // Results are matched against the oldest expectation
    always @(posedge aclk)
    begin
        if (rv && rrd)
            `CHK({rr, rdat}, rd_q.pop_front())
        if (bv && brd)
            `CHK(br, b_q.pop_front())
        if (cpu_rsp.load_pc)
            `CHK(cpu_rsp.pc, pc_q.pop_front())
        if (cpu_rsp.load_af)
            `CHK({cpu_rsp.flags, cpu_rsp.acc}, af_q.pop_front())
    end

    // Hang guard, far above the run's length
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    initial
    begin
        logic [31:0] r;
        logic [6:0]  e;
        logic [15:0] pc0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFS_ENABLE, 32'h0);
        axi_rd(OFS_REQUEST, 32'h0);
        axi_rd(OFS_EDGE, 32'h1555);
        axi_rd(OFS_SP, 32'h0);
        axi_rd(OFS_CTRL, 32'h0);
        axi_rd(OFS_EVT_MASK, 32'h0);
        axi_wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
        $display("reset test done");
        // All edge codes on all seven lines; enables off, so no dispatch
        ins(5'h10);
        for (int m = 0; m < 4; m++)
        begin
            axi_wr(OFS_EDGE, {18'h0, {7{2'(m)}}});
            axi_wr(OFS_REQUEST, 32'h0);
            src <= 7'h7F;
            repeat (8) @(posedge aclk);
            axi_rd(OFS_REQUEST, (m == 2) ? 32'h0 : 32'h7F);
            axi_wr(OFS_REQUEST, 32'h0);
            src <= 7'h00;
            repeat (8) @(posedge aclk);
            axi_rd(OFS_REQUEST, (m == 1) ? 32'h0 : 32'h7F);
        end
        $display("edge test done");
        e = 7'h7F;
        repeat (3)
        begin
            r = rnd();
            e = e & r[6:0];
            axi_wr(OFS_REQUEST, r);
            axi_rd(OFS_REQUEST, {25'h0, e});
        end
        $display("clear test done");
        r = rnd();
        pc0 = r[15:0];
        axi_wr(OFS_EDGE, 32'h1555);
        axi_wr(OFS_SP, 32'h20);
        axi_wr(OFS_EVT_MASK, 32'h3);
        axi_wr(OFS_REQUEST, 32'h0);
        axi_wr(OFS_ENABLE, 32'h0C);
        cpu_req.pc <= pc0;
        pc_q.push_back(VECTOR_ADDR);
        src <= 7'h08;
        repeat (10) @(posedge aclk);
        `CHK(irq, 1'b1)
        axi_rd(OFS_SP, 32'h22);
        axi_rd(OFS_EVT, 32'h1);
        axi_rd(OFS_EVT, 32'h0);
        `CHK(irq, 1'b0)
        cpu_req.acc <= r[23:16];
        cpu_req.flags <= r[31:24];
        af_q.push_back(r[31:16]);
        ins(5'h02);
        axi_rd(OFS_SP, 32'h24);
        cpu_req.acc <= ~r[23:16];
        ins(5'h01);
        axi_rd(OFS_SP, 32'h22);
        $display("entry test done");
        // Request held off by the handler; it is taken right after return
        src <= 7'h0C;
        repeat (8) @(posedge aclk);
        axi_wr(OFS_REQUEST, 32'h77);
        axi_wr(OFS_EVT_MASK, 32'h0);
        pc_q.push_back(pc0);
        pc_q.push_back(VECTOR_ADDR);
        ins(5'h04);
        repeat (8) @(posedge aclk);
        axi_rd(OFS_SP, 32'h22);
        `CHK(irq, 1'b0)
        axi_rd(OFS_EVT, 32'h3);
        axi_wr(OFS_REQUEST, 32'h0);
        pc_q.push_back(pc0);
        ins(5'h04);
        axi_rd(OFS_SP, 32'h20);
        ins(5'h08);
        src <= 7'h00;
        repeat (8) @(posedge aclk);
        src <= 7'h08;
        repeat (8) @(posedge aclk);
        axi_rd(OFS_REQUEST, 32'h8);
        axi_rd(OFS_CTRL, 32'h0);
        `CHK(pc_q.size(), 0)
        $display("return test done");
        give_verdict();
    end
endmodule // mic_irq_ctrl_tb
